// [obcd_pkg.sv]
// constants, field layout and carrier types of the option byte decoder
// assumes one 25 MHz cpu clock and an active low asynchronous reset
package obcd_pkg;
	localparam logic [7:0] OBCD_BYTE_RESET = 8'hFF;
	localparam int OBCD_B0_HALT = 7;
	localparam int OBCD_B0_WDT = 6;
	localparam int OBCD_B0_CLK = 5;
	localparam int OBCD_B0_VD_HI = 4;
	localparam int OBCD_B0_VD_LO = 3;
	localparam int OBCD_B0_RST = 2;
	localparam int OBCD_B0_DIV = 1;
	localparam int OBCD_B0_PROT = 0;
	localparam int OBCD_B1_PKG_HI = 7;
	localparam int OBCD_B1_PKG_LO = 5;
	localparam int OBCD_B1_MCO_HI = 1;
	localparam int OBCD_B1_MCO_LO = 0;
	localparam int OBCD_RST_LONG = 4096;
	localparam int OBCD_RST_SHORT = 256;
	localparam logic [12:0] OBCD_RST_LONG_W = 13'h1000;
	localparam logic [12:0] OBCD_RST_SHORT_W = 13'h0100;
	typedef enum logic [2:0] {
		OBCD_PKG_32, OBCD_PKG_44, OBCD_PKG_56, OBCD_PKG_64, OBCD_PKG_80
	} obcd_pkg_t;
	typedef enum logic [1:0] {OBCD_MCO_HIZ, OBCD_MCO_LOW, OBCD_MCO_HIGH} obcd_mco_t;
	typedef struct packed {
		logic halt_watchdog_reset;
		logic watchdog_always_on;
		logic use_pll;
		logic low_voltage_detector;
		logic auxiliary_voltage_detector;
		logic [12:0] reset_cycles;
		logic halve_input;
		logic readout_protect;
		obcd_pkg_t package_sel;
		obcd_mco_t motor_output_reset_state;
	} obcd_cfg_t;
endpackage

// [obcd_input_halving_opt.sv]
// optional divide by two of the oscillator input as a clock enable
// assumes the oscillator edge pulse already synchronised to clk
`timescale 1ns/100ps
module obcd_input_halving_opt import obcd_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic halve,
	input wire logic osc_edge,
	output logic osc_en_ff
);
	logic phase_ff;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_ff <= 1'b0;
			osc_en_ff <= 1'b0;
		end else begin
			if (osc_edge)
				phase_ff <= ~phase_ff;
			osc_en_ff <= osc_edge & (~halve | phase_ff);
		end
	end
endmodule

// [obcd_top.sv]
// option byte decode: holds two programmer written bytes, decodes configuration
// assumes the programmer port is synchronous to clk, the oscillator input is not
`timescale 1ns/100ps
module obcd_top import obcd_pkg::*; (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_circuit_programming_mode,
	input wire logic test_mode,
	input wire logic prog_wr,
	input wire logic prog_sel,
	input wire logic [7:0] prog_wdata,
	input wire logic prog_erase,
	input wire logic prog_mem_req,
	input wire logic erase_done,
	input wire logic oscillator_input,
	input wire logic halt_entry,
	input wire logic watchdog_active,
	input wire logic watchdog_sw_enable,
	output logic [7:0] prog_rdata_ff,
	output logic prog_mem_grant_ff,
	output logic user_erase_req_ff,
	output obcd_cfg_t cfg_ff,
	output logic watchdog_run_ff,
	output logic halt_reset_ff,
	output logic osc_en_ff,
	output logic [1:0] motor_out_ff,
	output logic motor_oe_b_ff
);
	////////////////////////////////////////////////////////////////
	// non volatile bytes, programmer only
	logic [7:0] byte0_ff = OBCD_BYTE_RESET;
	logic [7:0] byte1_ff = OBCD_BYTE_RESET;
	logic erase_pend_ff;
	logic boot_ff;
	wire prog_ok = in_circuit_programming_mode;
	wire protected_now = ~byte0_ff[OBCD_B0_PROT];
	wire erase_hit = prog_ok & prog_erase & ~erase_pend_ff;
	wire wr_ok = prog_ok & prog_wr & ~prog_erase & ~erase_pend_ff;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			erase_pend_ff <= 1'b0;
			user_erase_req_ff <= 1'b0;
		end else begin
			if (erase_hit & protected_now) begin
				erase_pend_ff <= 1'b1;
				user_erase_req_ff <= 1'b1;
			end else if (erase_pend_ff & erase_done) begin
				erase_pend_ff <= 1'b0;
				user_erase_req_ff <= 1'b0;
			end
		end
	end
	// storage survives reset; only erase brings it back to all ones
	always_ff @(posedge clk) begin
		if ((erase_hit & ~protected_now) | (erase_pend_ff & erase_done)) begin
			byte0_ff <= OBCD_BYTE_RESET;
			byte1_ff <= OBCD_BYTE_RESET;
		end else if (wr_ok & ~prog_sel)
			byte0_ff <= prog_wdata;
		else if (wr_ok & prog_sel)
			byte1_ff <= prog_wdata;
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prog_rdata_ff <= 8'h00;
			prog_mem_grant_ff <= 1'b0;
		end else begin
			prog_rdata_ff <= prog_ok ? (prog_sel ? byte1_ff : byte0_ff) : 8'h00;
			prog_mem_grant_ff <= prog_mem_req & (prog_ok | test_mode) & ~cfg_ff.readout_protect;
		end
	end
	////////////////////////////////////////////////////////////////
	// decode
	function automatic obcd_cfg_t decode(input logic [7:0] b0, input logic [7:0] b1);
		obcd_cfg_t c;
		logic [1:0] vd;
		logic [2:0] pk;
		logic [1:0] mc;
		vd = b0[OBCD_B0_VD_HI:OBCD_B0_VD_LO];
		pk = b1[OBCD_B1_PKG_HI:OBCD_B1_PKG_LO];
		mc = b1[OBCD_B1_MCO_HI:OBCD_B1_MCO_LO];
		c.halt_watchdog_reset = b0[OBCD_B0_HALT];
		c.watchdog_always_on = ~b0[OBCD_B0_WDT];
		c.use_pll = ~b0[OBCD_B0_CLK];
		c.low_voltage_detector = (vd != 2'b10);
		c.auxiliary_voltage_detector = (vd == 2'b00) | (vd == 2'b11);
		c.reset_cycles = (~b0[OBCD_B0_CLK] | ~b0[OBCD_B0_RST]) ?
			OBCD_RST_LONG_W : OBCD_RST_SHORT_W;
		c.halve_input = ~b0[OBCD_B0_DIV];
		c.readout_protect = ~b0[OBCD_B0_PROT];
		case (pk)
			3'h0: c.package_sel = OBCD_PKG_32;
			3'h1: c.package_sel = OBCD_PKG_44;
			3'h2: c.package_sel = OBCD_PKG_56;
			3'h3: c.package_sel = OBCD_PKG_64;
			default: c.package_sel = OBCD_PKG_80;
		endcase
		case (mc)
			2'h1: c.motor_output_reset_state = OBCD_MCO_LOW;
			2'h2: c.motor_output_reset_state = OBCD_MCO_HIGH;
			default: c.motor_output_reset_state = OBCD_MCO_HIZ;
		endcase
		return c;
	endfunction
	wire obcd_cfg_t cfg_now = decode(byte0_ff, byte1_ff);
	localparam obcd_cfg_t OBCD_CFG_DFLT = decode(OBCD_BYTE_RESET, OBCD_BYTE_RESET);
	////////////////////////////////////////////////////////////////
	// sample once after reset release, hold until next reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			boot_ff <= 1'b1;
			cfg_ff <= OBCD_CFG_DFLT;
		end else begin
			boot_ff <= 1'b0;
			if (boot_ff)
				cfg_ff <= cfg_now;
		end
	end
	////////////////////////////////////////////////////////////////
	// consumers of the configuration
	wire wd_on = cfg_ff.watchdog_always_on | watchdog_sw_enable;
	logic osc_s1_ff, osc_s2_ff, osc_s3_ff;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			watchdog_run_ff <= 1'b0;
			halt_reset_ff <= 1'b0;
			osc_s1_ff <= 1'b0;
			osc_s2_ff <= 1'b0;
			osc_s3_ff <= 1'b0;
		end else begin
			watchdog_run_ff <= wd_on;
			halt_reset_ff <= halt_entry & watchdog_active & cfg_ff.halt_watchdog_reset;
			osc_s1_ff <= oscillator_input;
			osc_s2_ff <= osc_s1_ff;
			osc_s3_ff <= osc_s2_ff;
		end
	end
	// motor port follows the live bytes while in reset, the held config after
	wire [1:0] mco_src = boot_ff ? cfg_now.motor_output_reset_state :
		cfg_ff.motor_output_reset_state;
	always_ff @(posedge clk) begin
		motor_out_ff <= mco_src;
		motor_oe_b_ff <= (mco_src == OBCD_MCO_HIZ);
	end
	obcd_input_halving_opt u_input_halving_opt (
		.clk(clk),
		.rst_b(rst_b),
		.halve(cfg_ff.halve_input),
		.osc_edge(osc_s2_ff & ~osc_s3_ff),
		.osc_en_ff(osc_en_ff)
	);
	////////////////////////////////////////////////////////////////
	// checks
	a_halt_reset: assert property (@(posedge clk) disable iff (!rst_b)
		(halt_entry & watchdog_active) |=> (halt_reset_ff == $past(cfg_ff.halt_watchdog_reset)))
		else $error("halt reset mismatch");
	a_pll_long: assert property (@(posedge clk) disable iff (!rst_b)
		cfg_ff.use_pll |-> cfg_ff.reset_cycles == OBCD_RST_LONG_W)
		else $error("pll must force long reset");
	a_cfg_hold: assert property (@(posedge clk) disable iff (!rst_b)
		!$past(boot_ff) |-> $stable(cfg_ff))
		else $error("config changed after sampling");
	a_prot_block: assert property (@(posedge clk) disable iff (!rst_b)
		cfg_ff.readout_protect |=> !prog_mem_grant_ff)
		else $error("protected access granted");
	a_hidden_read: assert property (@(posedge clk) disable iff (!rst_b)
		!in_circuit_programming_mode |=> prog_rdata_ff == 8'h00)
		else $error("option bytes visible outside programming");
	a_wdt_hw: assert property (@(posedge clk) disable iff (!rst_b)
		cfg_ff.watchdog_always_on |=> watchdog_run_ff)
		else $error("hardware watchdog stopped");
	a_erase_first: assert property (@(posedge clk) disable iff (!rst_b)
		(erase_hit & protected_now) |=> user_erase_req_ff & $stable(byte0_ff))
		else $error("protected erase skipped user memory");
	a_lvd_off: assert property (@(posedge clk) disable iff (!rst_b)
		!cfg_ff.low_voltage_detector |-> !cfg_ff.auxiliary_voltage_detector)
		else $error("aux detector on without low detector");
	a_mco_oe: assert property (@(posedge clk) disable iff (!rst_b)
		!boot_ff |=> (motor_oe_b_ff == ($past(cfg_ff.motor_output_reset_state) == OBCD_MCO_HIZ)))
		else $error("motor output enable wrong");
	c_halt_reset: cover property (@(posedge clk) disable iff (!rst_b) halt_reset_ff);
	c_prot_erase: cover property (@(posedge clk) disable iff (!rst_b) user_erase_req_ff ##[1:20] !user_erase_req_ff);
	c_grant: cover property (@(posedge clk) disable iff (!rst_b) prog_mem_grant_ff);
	c_short_rst: cover property (@(posedge clk) disable iff (!rst_b) cfg_ff.reset_cycles == OBCD_RST_SHORT_W);
endmodule

// [obcd_prog_model.sv]
// programmer tool model: writes and erases the option bytes
// assumes the bench calls its tasks; clk is the device clock
`timescale 1ns/100ps
module obcd_prog_model (
	input wire logic clk,
	output logic in_circuit_programming_mode,
	output logic prog_wr,
	output logic prog_sel,
	output logic [7:0] prog_wdata,
	output logic prog_erase
);
	initial begin
		{in_circuit_programming_mode, prog_wr, prog_sel, prog_erase} = 4'h0;
		prog_wdata = 8'h00;
	end
	// one cycle write or erase, data inverted once released
	task pulse(logic s, logic [7:0] d, logic er);
		@(negedge clk);
		prog_sel = s;
		prog_wdata = d;
		prog_wr = !er;
		prog_erase = er;
		@(negedge clk);
		{prog_wr, prog_erase} = 2'h0;
		prog_wdata = ~d;
	endtask
	// byte access only while in programming mode
	task setm(logic m, logic s);
		in_circuit_programming_mode = m;
		prog_sel = s;
	endtask
endmodule

// [option_byte_config_decode_bench.sv]
// bench: random option bytes, decode after reset, gates and erase
// assumes the programmer model drives the byte port at falling edges
`timescale 1ns/100ps
module option_byte_config_decode_bench;
	import obcd_pkg::*;
	logic clk = 1'h0, rst_b = 1'h0, test_mode = 1'h0, prog_mem_req = 1'h0;
	logic erase_done = 1'h0, halt_entry = 1'h0, watchdog_active = 1'h0;
	logic watchdog_sw_enable = 1'h0;
	logic osc = 1'h0;
	logic [3:0] n_osc = 4'h0, x_osc = 4'h0;
	wire logic mode, prog_wr, prog_sel, prog_erase;
	wire logic [7:0] prog_wdata;
	logic [7:0] prog_rdata_ff, b0 = 8'hFF, b1 = 8'hFF, lat0 = 8'hFF, lat1 = 8'hFF;
	logic grant, uer, wrun, hrst, osc_en, m_oe_b;
	logic [1:0] m_out;
	obcd_cfg_t cfg_ff;
	logic [31:0] seed = 32'h668E;
	logic [43:0] q[$];
	int n_mismatch = 0, cmp_count = 0;
	wire logic [39:0] obs = {cfg_ff, prog_rdata_ff, wrun, hrst, grant, uer, m_out, m_oe_b};
	obcd_top dut (.clk(clk), .rst_b(rst_b), .in_circuit_programming_mode(mode),
		.test_mode(test_mode), .prog_wr(prog_wr), .prog_sel(prog_sel),
		.prog_wdata(prog_wdata), .prog_erase(prog_erase), .prog_mem_req(prog_mem_req),
		.erase_done(erase_done), .oscillator_input(osc), .halt_entry(halt_entry),
		.watchdog_active(watchdog_active), .watchdog_sw_enable(watchdog_sw_enable),
		.prog_rdata_ff(prog_rdata_ff), .prog_mem_grant_ff(grant), .user_erase_req_ff(uer),
		.cfg_ff(cfg_ff), .watchdog_run_ff(wrun), .halt_reset_ff(hrst), .osc_en_ff(osc_en),
		.motor_out_ff(m_out), .motor_oe_b_ff(m_oe_b));
	obcd_prog_model prog (.clk(clk), .in_circuit_programming_mode(mode), .prog_wr(prog_wr),
		.prog_sel(prog_sel), .prog_wdata(prog_wdata), .prog_erase(prog_erase));
	initial forever #20 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic obcd_cfg_t dec(logic [7:0] a, logic [7:0] b);
		return '{a[7], !a[6], !a[5], a[4:3] != 2'h2, a[4] == a[3],
			(a[2] && a[5]) ? 13'h0100 : 13'h1000, !a[1], !a[0],
			b[7] ? OBCD_PKG_80 : obcd_pkg_t'({1'h0, b[6:5]}),
			obcd_mco_t'((b[1:0] == 2'h3) ? 2'h0 : b[1:0])};
	endfunction
	function automatic logic [2:0] mc(logic [1:0] m);
		return {(m == 2'h3) ? 2'h0 : m, m == 2'h0 || m == 2'h3};
	endfunction
	task automatic check(logic [43:0] seen, logic [43:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task results();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// watcher: oldest note against the settled outputs
	always @(posedge clk) begin
		#1;
		if (osc_en)
			n_osc++;
		if (q.size() > 0) check({obs, n_osc}, q.pop_front());
	end
	task automatic rst();
		@(negedge clk);
		rst_b = 1'h0;
		n_osc = 4'h0;
		x_osc = 4'h0;
		repeat (5) begin
			q.push_back({dec(8'hFF, 8'hFF), 12'h000, mc(b1[1:0]), 4'h0});
			@(negedge clk);
		end
		rst_b = 1'h1;
		repeat (2) @(posedge clk);
		lat0 = b0;
		lat1 = b1;
	endtask
	task automatic step(logic m, logic s, logic e);
		logic [31:0] r;
		r = xs();
		@(negedge clk);
		{halt_entry, watchdog_active, watchdog_sw_enable, prog_mem_req, test_mode} = r[4:0];
		prog.setm(m, s);
		q.push_back({dec(lat0, lat1), m ? (s ? b1 : b0) : 8'h00, !lat0[6] || r[2],
			r[4] && r[3] && lat0[7], r[1] && (m || r[0]) && lat0[0], e,
			mc(lat1[1:0]), x_osc});
	endtask
	// five oscillator rises right after reset, phase starts at zero
	task automatic osc_burst();
		repeat (5) begin
			@(negedge clk) osc = 1'h1;
			@(negedge clk) osc = 1'h0;
		end
		@(negedge clk);
		x_osc = lat0[1] ? 4'h5 : 4'h2;
	endtask
	initial begin
		logic [31:0] r;
		rst();
		for (int i = 0; i < 16; i++) begin
			r = xs();
			r[5:1] = {i[3], i[1:0], i[2], i[0]};
			r[9:8] = i[1:0];
			r[15:13] = i[2:0];
			if (i == 15) r[0] = 1'h0;
			step(1'h0, 1'h0, 1'h0);
			prog.pulse(1'h0, ~r[7:0], 1'h0);
			step(1'h1, 1'h0, 1'h0);
			prog.pulse(1'h0, r[7:0], 1'h0);
			prog.pulse(1'h1, r[15:8], 1'h0);
			b0 = r[7:0];
			b1 = r[15:8];
			for (int k = 0; k < 8; k++) begin
				if (k == 4) begin
					rst();
					osc_burst();
				end
				step(r[16 + k], r[24 + k], 1'h0);
			end
		end
		// protected erase: user memory first, then blank bytes
		step(1'h1, 1'h0, 1'h0);
		prog.pulse(1'h0, 8'h00, 1'h1);
		step(1'h0, 1'h0, 1'h1);
		step(1'h0, 1'h0, 1'h1);
		@(negedge clk) erase_done = 1'h1;
		@(negedge clk) erase_done = 1'h0;
		b0 = 8'hFF;
		b1 = 8'hFF;
		step(1'h1, 1'h0, 1'h0);
		step(1'h1, 1'h1, 1'h0);
		rst();
		step(1'h1, 1'h0, 1'h0);
		// unprotected erase blanks the bytes at once
		prog.pulse(1'h0, 8'hA5, 1'h0);
		b0 = 8'hA5;
		step(1'h1, 1'h0, 1'h0);
		prog.pulse(1'h0, 8'h00, 1'h1);
		b0 = 8'hFF;
		step(1'h1, 1'h0, 1'h0);
		repeat (2) @(posedge clk);
		results();
	end
	initial begin
		#2000000;
		n_mismatch++;
		results();
	end
endmodule
